// ==== hw/cskp_pkg.sv ====
package cskp_pkg;

   // Data and parity widths
   localparam int DATA_W   = 16;
   localparam int PAR_W    = 2;

   // Delay-line recovery, in input clock periods
   localparam int RECOVER_CLKS = 8;
   localparam logic [3:0] RECOVER_CNT = 4'(RECOVER_CLKS);

   // Clock-stop detector: input clock considered stopped after this many
   // system clocks without a sampled edge
   localparam logic [7:0] STOP_DET_CNT = 8'h20;

   // Reset values
   localparam logic [15:0] DATA_RST = 16'h0000;
   localparam logic [1:0]  PAR_RST  = 2'h0;

   typedef enum logic [3:0] {
      CSKP_NORMAL  = 4'b0001,
      CSKP_GRANT   = 4'b0010,
      CSKP_FROZEN  = 4'b0100,
      CSKP_RECOVER = 4'b1000
   } cskp_state_t;

endpackage

// ==== hw/cskp_sync.sv ====
`timescale 1ns/10ps
module cskp_sync #(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_sys_rst,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] meta;

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         meta   <= '0;
         o_sync <= '0;
      end else begin
         meta   <= i_async;
         o_sync <= meta;
      end
   end
endmodule

// ==== hw/cskp_top.sv ====
`timescale 1ns/10ps
// What this block does
// - Parity lines are held at the last applied level except in bus hold; data lines only in halt.
// - Level briefly driven from outside is taken over and kept after release, on data lines in halt only, on parity lines outside bus hold.
// - Parity line keepers stay enabled in every power state, except during bus hold.
// - Prior-state pins keep their level captured on entering granted halt.
// - Internal clocks come from the input clock through a delay line.
// - Delay-line generator recovers within eight input clock periods.
// - Input clock stopped in granted halt means the clock-frozen state.
// - After clock restart, granted halt is re-entered within eight clocks.
// - Deasserting the halt request returns granted halt to normal.
// - Hold in granted halt is acknowledged, lines float, then restored.
// - Data line keepers are enabled only in granted halt, frozen or recovery.
module cskp_top
   import cskp_pkg::*;
#(
   parameter int DW = DATA_W,
   parameter int PW = PAR_W,
   parameter int PRIOR_W = 8
) (
   input  wire logic          i_clk,
   input  wire logic          i_sys_rst,
   input  wire logic          i_ext_clk,
   input  wire logic          i_clock_halt_request_n,
   input  wire logic          i_bus_hold_request,
   input  wire logic [DW-1:0] i_data_pin,
   input  wire logic [PW-1:0] i_parity_pin,
   input  wire logic [DW-1:0] i_core_data,
   input  wire logic [PW-1:0] i_core_parity,
   input  wire logic          i_core_drive,
   input  wire logic [PRIOR_W-1:0] i_core_prior,
   output logic [DW-1:0]      o_sixteen_bit_data_lines,
   output logic               o_data_oe,
   output logic [PW-1:0]      o_byte_parity_lines,
   output logic [PW-1:0]      o_parity_oe,
   output logic [PRIOR_W-1:0] o_prior_pins,
   output logic               o_bus_hold_acknowledge,
   output logic               o_halt_granted,
   output logic               o_clock_frozen,
   output logic               o_delay_line_clock_generator_locked,
   output logic               o_core_clk_en
);

   localparam int SW = DW + PW + 3;

   logic [SW-1:0] sync_out;
   logic [DW-1:0] data_s;
   logic [PW-1:0] par_s;
   logic          halt_req_s;
   logic          hold_s;
   logic          ext_clk_s;
   logic          ext_clk_d;
   logic          ext_edge;

   cskp_sync #(.W(SW)) u_sync (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_async   ({i_data_pin, i_parity_pin, ~i_clock_halt_request_n,
                   i_bus_hold_request, i_ext_clk}),
      .o_sync    (sync_out)
   );

   assign data_s     = sync_out[SW-1 -: DW];
   assign par_s      = sync_out[3 +: PW];
   assign halt_req_s = sync_out[2];
   assign hold_s     = sync_out[1];
   assign ext_clk_s  = sync_out[0];

   // Rising edge of the input clock, seen in the system domain
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ext_clk_d <= 1'b0;
      end else begin
         ext_clk_d <= ext_clk_s;
      end
   end

   assign ext_edge = ext_clk_s & ~ext_clk_d;

   // Input clock activity: stopped when no edge for STOP_DET_CNT cycles
   logic [7:0] idle_cnt;
   logic       clk_stopped;

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         idle_cnt <= 8'h00;
      end else if (ext_edge) begin
         idle_cnt <= 8'h00;
      end else if (idle_cnt != STOP_DET_CNT) begin
         idle_cnt <= idle_cnt + 8'h01;
      end
   end

   assign clk_stopped = (idle_cnt == STOP_DET_CNT);

   // Delay-line generator: recovery counted in input clock edges
   logic [3:0] lock_cnt;
   logic       locked;

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         lock_cnt <= 4'h0;
      end else if (ext_edge && lock_cnt != RECOVER_CNT) begin
         lock_cnt <= lock_cnt + 4'h1;
      end else if (clk_stopped) begin
         lock_cnt <= 4'h0;
      end
   end

   assign locked = (lock_cnt == RECOVER_CNT);

   // Power state machine
   cskp_state_t state;
   cskp_state_t next_state;

   always_comb begin
      next_state = state;
      case (state)
         CSKP_NORMAL: begin
            if (halt_req_s) begin
               next_state = CSKP_GRANT;
            end
         end
         CSKP_GRANT: begin
            if (clk_stopped) begin
               next_state = CSKP_FROZEN;
            end else if (!halt_req_s) begin
               next_state = CSKP_NORMAL;
            end
         end
         CSKP_FROZEN: begin
            if (!clk_stopped) begin
               next_state = CSKP_RECOVER;
            end
         end
         CSKP_RECOVER: begin
            if (clk_stopped) begin
               next_state = CSKP_FROZEN;
            end else if (locked) begin
               next_state = CSKP_GRANT;
            end
         end
         default: begin
            next_state = CSKP_NORMAL;
         end
      endcase
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state <= CSKP_NORMAL;
      end else begin
         state <= next_state;
      end
   end

   logic low_power;
   logic hold_active;
   logic next_low_power;

   assign low_power      = (state != CSKP_NORMAL);
   assign next_low_power = (next_state != CSKP_NORMAL);
   assign hold_active    = hold_s && (state == CSKP_GRANT)
                           && (next_state == CSKP_GRANT);

   // Prior-state pins captured on entry to granted halt
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_prior_pins <= '0;
      end else if (!low_power) begin
         o_prior_pins <= i_core_prior;
      end
   end

   // Kept levels: follow core while it drives, else adopt pin levels
   logic [DW-1:0] data_keep;
   logic [PW-1:0] par_keep;
   logic [1:0]    data_oe_hist;
   logic [1:0]    par_oe_hist;
   logic          data_pin_ok;
   logic          par_pin_ok;

   // Synced pin level trusted only once sampled while driven
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         data_oe_hist <= 2'h0;
         par_oe_hist  <= 2'h0;
      end else begin
         data_oe_hist <= {data_oe_hist[0], o_data_oe};
         par_oe_hist  <= {par_oe_hist[0], o_parity_oe[0]};
      end
   end

   assign data_pin_ok = o_data_oe && (data_oe_hist == 2'h3);
   assign par_pin_ok  = o_parity_oe[0] && (par_oe_hist == 2'h3);

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         data_keep <= DATA_RST;
      end else if (!next_low_power && i_core_drive) begin
         data_keep <= i_core_data;
      end else if (low_power && !hold_active && data_pin_ok) begin
         data_keep <= data_s;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         par_keep <= PAR_RST;
      end else if (!next_low_power && i_core_drive) begin
         par_keep <= i_core_parity;
      end else if (!hold_active && par_pin_ok) begin
         par_keep <= par_s;
      end
   end

   // Pin drive: keeper overpowered by stronger outside drivers
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_sixteen_bit_data_lines <= DATA_RST;
         o_byte_parity_lines      <= PAR_RST;
         o_data_oe                <= 1'b0;
         o_parity_oe              <= '0;
      end else begin
         if (!next_low_power && i_core_drive) begin
            o_sixteen_bit_data_lines <= i_core_data;
            o_byte_parity_lines      <= i_core_parity;
         end else begin
            o_sixteen_bit_data_lines <= data_keep;
            o_byte_parity_lines      <= par_keep;
         end
         o_data_oe   <= (next_low_power && !hold_active)
                        || (!next_low_power && i_core_drive);
         o_parity_oe <= {PW{!hold_active}};
      end
   end

   // Status outputs
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_bus_hold_acknowledge              <= 1'b0;
         o_halt_granted                      <= 1'b0;
         o_clock_frozen                      <= 1'b0;
         o_delay_line_clock_generator_locked <= 1'b0;
         o_core_clk_en                       <= 1'b0;
      end else begin
         o_bus_hold_acknowledge <= hold_active;
         o_halt_granted <= (next_state == CSKP_GRANT);
         o_clock_frozen <= (next_state == CSKP_FROZEN)
                           || (next_state == CSKP_RECOVER);
         o_delay_line_clock_generator_locked <= locked;
         o_core_clk_en <= locked && (next_state == CSKP_NORMAL);
      end
   end

endmodule

// ==== tb/cskp_sva.sv ====
`timescale 1ns/10ps
module cskp_sva #(
   parameter int PRIOR_W = 8
) (
   input wire logic               i_clk,
   input wire logic               i_sys_rst,
   input wire logic               i_clock_halt_request_n,
   input wire logic [15:0]        i_data_pin,
   input wire logic [15:0]        o_sixteen_bit_data_lines,
   input wire logic               o_data_oe,
   input wire logic [1:0]         o_parity_oe,
   input wire logic [PRIOR_W-1:0] o_prior_pins,
   input wire logic               o_bus_hold_acknowledge,
   input wire logic               o_halt_granted,
   input wire logic               o_clock_frozen,
   input wire logic               o_core_clk_en
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   sequence s_req_held;
      !i_clock_halt_request_n [*5];
   endsequence
   sequence s_req_gone;
      (i_clock_halt_request_n && !o_clock_frozen) [*5];
   endsequence
   sequence s_keep_quiet;
      (o_halt_granted && !o_bus_hold_acknowledge && $stable(i_data_pin)) [*5];
   endsequence
   a_grant_after_req: assert property (s_req_held |-> o_halt_granted || o_clock_frozen)
      else $error("halt not granted");
   a_release_to_normal: assert property (s_req_gone |-> !o_halt_granted)
      else $error("halt not left");
   a_data_adopted: assert property (s_keep_quiet |-> o_sixteen_bit_data_lines == i_data_pin)
      else $error("data level not kept");
   a_hold_floats_bus: assert property (o_bus_hold_acknowledge |-> !o_data_oe && o_parity_oe == 2'h0)
      else $error("bus not floated in hold");
   a_hold_in_grant: assert property ($rose(o_bus_hold_acknowledge) |-> o_halt_granted)
      else $error("hold acknowledged outside halt");
   a_keeper_on_grant: assert property ($rose(o_halt_granted) |-> o_data_oe)
      else $error("data keeper off in halt");
   a_parity_keep_on: assert property (!o_bus_hold_acknowledge [*2] ##0 !$past(i_sys_rst, 2) |-> o_parity_oe == 2'h3)
      else $error("parity keeper off");
   a_frozen_from_grant: assert property ($rose(o_clock_frozen) |-> $past(o_halt_granted))
      else $error("frozen without halt");
   a_prior_held: assert property (o_halt_granted && $past(o_halt_granted) |-> $stable(o_prior_pins))
      else $error("prior pins moved");
   a_core_stopped: assert property (o_halt_granted && $past(o_halt_granted) |-> !o_core_clk_en)
      else $error("core runs in halt");
endmodule
bind cskp_top cskp_sva #(.PRIOR_W(PRIOR_W)) u_sva (.*);

// ==== tb/cskp_sys_model.sv ====
`timescale 1ns/10ps
module cskp_sys_model (
   input  wire logic i_run,
   input  wire logic i_halt,
   input  wire logic i_granted,
   output logic      o_ext_clk,
   output logic      o_halt_n
);
   logic stop;
   // Fixed period, so no drift while running
   initial begin
      o_ext_clk = 1'b0;
      stop = 1'b0;
      forever #20 o_ext_clk = stop ? 1'b0 : ~o_ext_clk;
   end
   // Clock stops only once halt is granted
   always @* begin
      if (i_run) stop = 1'b0;
      else if (i_granted) stop = 1'b1;
   end
   assign o_halt_n = !i_halt;
endmodule

// ==== tb/cskp_top_bench.sv ====
`timescale 1ns/10ps
module cskp_top_bench;
   logic clk, rst, run, halt, hold, ext_en, drive, ext_clk, halt_n;
   logic [15:0] ext_d, cd, data_pin, data_o;
   logic [1:0]  ext_p, par_pin, par_o, par_oe;
   logic [7:0]  prior, prior_o;
   logic        data_oe, ack, granted, frozen, locked, clk_en;
   int          num_errors, cmp_count, cyc;
   logic [15:0] rd[3] = '{16'hA5C3, 16'h0000, 16'hFFFF};
   logic [1:0]  rp[3] = '{2'h2, 2'h0, 2'h3};
   assign data_pin = ext_en ? ext_d : (data_oe ? data_o : ~data_o);
   assign par_pin = ext_en ? ext_p : ~(par_oe ^ par_o);
   cskp_sys_model u_sys (.i_run(run), .i_halt(halt), .i_granted(granted),
      .o_ext_clk(ext_clk), .o_halt_n(halt_n));
   cskp_top dut (.i_clk(clk), .i_sys_rst(rst), .i_ext_clk(ext_clk),
      .i_clock_halt_request_n(halt_n), .i_bus_hold_request(hold),
      .i_data_pin(data_pin), .i_parity_pin(par_pin), .i_core_data(cd),
      .i_core_parity(2'h1), .i_core_drive(drive), .i_core_prior(prior),
      .o_sixteen_bit_data_lines(data_o), .o_data_oe(data_oe),
      .o_byte_parity_lines(par_o), .o_parity_oe(par_oe),
      .o_prior_pins(prior_o), .o_bus_hold_acknowledge(ack),
      .o_halt_granted(granted), .o_clock_frozen(frozen),
      .o_delay_line_clock_generator_locked(locked), .o_core_clk_en(clk_en));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task close_out;
      $display("errors %0d checks %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 1500) begin
         num_errors++;
         close_out;
      end
   end
   initial begin
      {rst, run, halt, hold, ext_en, drive} = 6'b110000;
      ext_d = 16'h0000;
      ext_p = 2'h0;
      cd = 16'h1234;
      prior = 8'hC3;
      step(3);
      chk("reset oe", 16'h0, 16'(data_oe));
      rst = 1'b0;
      drive = 1'b1;
      step(6);
      chk("core data", 16'h1234, data_o);
      chk("parity oe", 16'h3, 16'(par_oe));
      drive = 1'b0;
      halt = 1'b1;
      step(5);
      chk("granted", 16'h1, 16'(granted));
      chk("keeper oe", 16'h1, 16'(data_oe));
      prior = 8'h3C;
      step(3);
      chk("prior", 16'hC3, 16'(prior_o));
      for (int i = 0; i < 3; i++) begin
         ext_d = rd[i];
         ext_p = rp[i];
         ext_en = 1'b1;
         step(6);
         ext_en = 1'b0;
         step(4);
         chk("kept data", rd[i], data_o);
         chk("kept parity", 16'(rp[i]), 16'(par_o));
      end
      hold = 1'b1;
      step(5);
      chk("hold ack", 16'h1, {15'h0, ack});
      chk("floated", 16'h0, {13'h0, data_oe, par_oe});
      hold = 1'b0;
      step(5);
      chk("restored", 16'hFFFF, data_o);
      run = 1'b0;
      step(60);
      chk("frozen", 16'h1, 16'(frozen));
      run = 1'b1;
      step(60);
      chk("thawed", 16'h3, {14'h0, granted, ~frozen});
      chk("locked", 16'h1, 16'(locked));
      halt = 1'b0;
      step(8);
      chk("running", 16'h3, {14'h0, ~granted, clk_en});
      close_out;
   end
endmodule
